// ### hdl/aws_pkg.sv
// Constants and types for the auto wake/sleep and boot status block
package aws_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] AWS_INT_STATUS_OFFSET = 8'h00;
  localparam logic [7:0] AWS_INT_STATUS_RESET  = 8'h00;
  localparam int         AWS_BOOT_BIT          = 0;
  localparam int         AWS_CHANGE_BIT        = 1;

  // ----------------------------------------
  // Field widths
  // ----------------------------------------
  localparam int AWS_CNT_BYTE_W = 8;
  localparam int AWS_CNT_W      = 2 * AWS_CNT_BYTE_W;
  localparam int AWS_PM_W       = 2;
  localparam int AWS_ODR_W      = 4;
  localparam int AWS_FLEX_W     = 4;

  localparam logic [AWS_CNT_W-1:0]  AWS_CNT_ZERO  = 16'h0000;
  localparam logic [AWS_CNT_W-1:0]  AWS_CNT_ONE   = 16'h0001;
  localparam logic [AWS_PM_W-1:0]   AWS_PM_RESET  = 2'h0;
  localparam logic [AWS_ODR_W-1:0]  AWS_ODR_RESET = 4'h0;
  localparam logic [AWS_FLEX_W-1:0] AWS_FLEX_RESET = 4'h0;

  // ----------------------------------------
  // System operating mode
  // ----------------------------------------
  typedef enum logic {
    AWS_MODE_WAKE,
    AWS_MODE_SLEEP
  } aws_mode_t;
endpackage

// ### hdl/aws_inact_if.sv
// Interface between the mode controller and the inactivity counter
`timescale 1ns/1ps
interface aws_inact_if;
  import aws_pkg::*;
  logic                 tick;
  logic                 event_seen;
  logic                 counting;
  logic [AWS_CNT_W-1:0] limit;
  logic                 expired;

  modport counter (
    input  tick,
    input  event_seen,
    input  counting,
    input  limit,
    output expired
  );
  modport ctrl (
    output tick,
    output event_seen,
    output counting,
    output limit,
    input  expired
  );
endinterface

// ### hdl/aws_inact_counter.sv
// Inactivity period counter measured in output data rate ticks
`timescale 1ns/1ps
module aws_inact_counter
  import aws_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  aws_inact_if.counter bus
);
  logic [AWS_CNT_W-1:0] count_q;

  // ----------------------------------------
  // Quiet period count
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count_q <= AWS_CNT_ZERO;
    end else if (bus.event_seen || !bus.counting) begin
      count_q <= AWS_CNT_ZERO;
    end else if (bus.tick) begin
      count_q <= count_q + AWS_CNT_ONE;
    end
  end

  // Expiry fires on the tick that completes the limit
  always_comb begin
    bus.expired = bus.counting && bus.tick && !bus.event_seen &&
                  (bus.limit != AWS_CNT_ZERO) &&
                  ((count_q + AWS_CNT_ONE) == bus.limit);
  end
endmodule

// ### hdl/aws_wake_sleep.sv
// Auto wake/sleep power mode control with change and boot status flags
`timescale 1ns/1ps

module aws_wake_sleep
  import aws_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  odr_tick_in,
  input  wire logic                  any_event_in,
  input  wire logic [AWS_CNT_BYTE_W-1:0] inactivity_count_low_in,
  input  wire logic [AWS_CNT_BYTE_W-1:0] inactivity_count_high_in,
  input  wire logic                  wake_sleep_event_enable_in,
  input  wire logic [AWS_PM_W-1:0]   wake_power_select_in,
  input  wire logic [AWS_PM_W-1:0]   sleep_power_select_in,
  input  wire logic [AWS_ODR_W-1:0]  wake_data_rate_in,
  input  wire logic [AWS_ODR_W-1:0]  sleep_data_rate_in,
  input  wire logic                  flex_mode_in,
  input  wire logic [AWS_FLEX_W-1:0] wake_decim_in,
  input  wire logic [AWS_FLEX_W-1:0] sleep_decim_in,
  input  wire logic [AWS_FLEX_W-1:0] wake_idle_in,
  input  wire logic [AWS_FLEX_W-1:0] sleep_idle_in,
  input  wire logic                  system_mode_read_in,
  input  wire logic                  boot_finished_in,
  input  wire logic                  soft_reset_in,
  input  wire logic                  hibernate_exit_in,
  output logic [7:0]                 interrupt_status_out,
  output logic                       system_mode_sleep_out,
  output logic [AWS_PM_W-1:0]        power_select_out,
  output logic [AWS_ODR_W-1:0]       output_data_rate_out,
  output logic [AWS_FLEX_W-1:0]      decim_out,
  output logic [AWS_FLEX_W-1:0]      idle_out
);
  aws_inact_if inact ();

  aws_mode_t            mode_q;
  logic                 change_flag_q;
  logic                 boot_flag_q;
  logic [AWS_PM_W-1:0]  pm_q;
  logic [AWS_ODR_W-1:0] odr_q;
  logic [AWS_FLEX_W-1:0] decim_q;
  logic [AWS_FLEX_W-1:0] idle_q;
  logic [AWS_CNT_W-1:0] limit;
  logic                 auto_on;
  logic                 go_sleep;
  logic                 go_wake;

  // ----------------------------------------
  // Inactivity counting
  // ----------------------------------------
  assign limit   = {inactivity_count_high_in, inactivity_count_low_in};
  assign auto_on = (limit != AWS_CNT_ZERO);

  assign inact.tick       = odr_tick_in;
  assign inact.event_seen = any_event_in;
  assign inact.counting   = auto_on && (mode_q == AWS_MODE_WAKE);
  assign inact.limit      = limit;

  aws_inact_counter u_counter (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .bus      (inact.counter)
  );

  assign go_sleep = inact.expired;
  // Wake on event even if the limit was zeroed while asleep
  assign go_wake  = (mode_q == AWS_MODE_SLEEP) && any_event_in;

  // ----------------------------------------
  // Operating mode
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_q <= AWS_MODE_WAKE;
    end else if (go_sleep) begin
      mode_q <= AWS_MODE_SLEEP;
    end else if (go_wake) begin
      mode_q <= AWS_MODE_WAKE;
    end
  end

  // ----------------------------------------
  // Power and rate settings
  // ----------------------------------------
  // Settings follow the next mode so they move in the same cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pm_q    <= AWS_PM_RESET;
      odr_q   <= AWS_ODR_RESET;
      decim_q <= AWS_FLEX_RESET;
      idle_q  <= AWS_FLEX_RESET;
    end else if (go_sleep || (mode_q == AWS_MODE_SLEEP && !go_wake)) begin
      pm_q    <= sleep_power_select_in;
      odr_q   <= sleep_data_rate_in;
      decim_q <= flex_mode_in ? sleep_decim_in : AWS_FLEX_RESET;
      idle_q  <= flex_mode_in ? sleep_idle_in : AWS_FLEX_RESET;
    end else begin
      pm_q    <= wake_power_select_in;
      odr_q   <= wake_data_rate_in;
      decim_q <= flex_mode_in ? wake_decim_in : AWS_FLEX_RESET;
      idle_q  <= flex_mode_in ? wake_idle_in : AWS_FLEX_RESET;
    end
  end

  // ----------------------------------------
  // Change flag
  // ----------------------------------------
  // Set beats the clearing read so no change is missed
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      change_flag_q <= 1'h0;
    end else if ((go_sleep || go_wake) && auto_on &&
                 wake_sleep_event_enable_in) begin
      change_flag_q <= 1'h1;
    end else if (system_mode_read_in) begin
      change_flag_q <= 1'h0;
    end
  end

  // ----------------------------------------
  // Boot done flag
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      boot_flag_q <= 1'h0;
    end else if (boot_finished_in) begin
      boot_flag_q <= 1'h1;
    end else if (soft_reset_in || hibernate_exit_in) begin
      boot_flag_q <= 1'h0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    interrupt_status_out                 = AWS_INT_STATUS_RESET;
    interrupt_status_out[AWS_CHANGE_BIT] = change_flag_q;
    interrupt_status_out[AWS_BOOT_BIT]   = boot_flag_q;
  end
  assign system_mode_sleep_out = (mode_q == AWS_MODE_SLEEP);
  assign power_select_out      = pm_q;
  assign output_data_rate_out  = odr_q;
  assign decim_out             = decim_q;
  assign idle_out              = idle_q;
endmodule

// ### test/aws_host_model.sv
// Data rate time base and host reads of the system mode
`timescale 1ns/1ps
module aws_host_model (
  input  wire logic clk_in,
  input  wire logic tick_en_in,
  output logic      odr_tick_out,
  output logic      mode_read_out
);
  initial odr_tick_out = 1'h0;
  initial mode_read_out = 1'h0;
  // Tick every cycle so inactivity limits stay short
  always @(posedge clk_in) odr_tick_out <= tick_en_in;
  task automatic read_mode();
    @(posedge clk_in) mode_read_out <= 1'h1;
    @(posedge clk_in) mode_read_out <= 1'h0;
  endtask
endmodule

// ### test/aws_wake_sleep_asserts.sv
// Port assertions for the auto wake/sleep block
`timescale 1ns/1ps
module aws_wake_sleep_chk
  import aws_pkg::*;
(
  input wire logic             clk_in,
  input wire logic             rst_n_in,
  input wire logic             any_event_in,
  input wire logic [7:0]       inactivity_count_low_in,
  input wire logic [7:0]       inactivity_count_high_in,
  input wire logic             wake_sleep_event_enable_in,
  input wire logic [1:0]       sleep_power_select_in,
  input wire logic             system_mode_read_in,
  input wire logic             boot_finished_in,
  input wire logic             soft_reset_in,
  input wire logic             hibernate_exit_in,
  input wire logic [7:0]       interrupt_status_out,
  input wire logic             system_mode_sleep_out,
  input wire logic [1:0]       power_select_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic flag = interrupt_status_out[AWS_CHANGE_BIT];
  wire logic boot = interrupt_status_out[AWS_BOOT_BIT];
  wire logic lim0 = {inactivity_count_high_in, inactivity_count_low_in} == '0;
  wire logic armed = wake_sleep_event_enable_in && !lim0;
  sequence s_flip;
    $changed(system_mode_sleep_out);
  endsequence
  sequence s_quiet_read;
    system_mode_read_in ##1 !$changed(system_mode_sleep_out);
  endsequence
  chk_flag_set: assert property (s_flip ##0 $past(armed) |-> flag)
    else $error("change flag missing after mode change");
  chk_flag_cause: assert property ($rose(flag) |-> s_flip ##0 $past(armed))
    else $error("change flag rose without enabled change");
  chk_read_clear: assert property (s_quiet_read |-> !flag)
    else $error("change flag kept after mode read");
  chk_zero_limit: assert property (!system_mode_sleep_out && lim0 |=> !system_mode_sleep_out)
    else $error("slept with zero limit");
  chk_event_wake: assert property (system_mode_sleep_out && any_event_in |=> !system_mode_sleep_out)
    else $error("event did not wake");
  chk_sleep_power: assert property (system_mode_sleep_out && $stable(sleep_power_select_in) |-> power_select_out == sleep_power_select_in)
    else $error("sleep power mode wrong");
  chk_boot_low: assert property (!boot && !boot_finished_in |=> !boot)
    else $error("boot flag rose early");
  chk_boot_hold: assert property (boot && !soft_reset_in && !hibernate_exit_in |=> boot)
    else $error("boot flag dropped");
  chk_boot_clear: assert property ((soft_reset_in || hibernate_exit_in) && !boot_finished_in |=> !boot)
    else $error("boot flag not cleared");
endmodule
bind aws_wake_sleep aws_wake_sleep_chk chk_u (.clk_in, .rst_n_in, .any_event_in, .inactivity_count_low_in, .inactivity_count_high_in, .wake_sleep_event_enable_in, .sleep_power_select_in, .system_mode_read_in, .boot_finished_in, .soft_reset_in, .hibernate_exit_in, .interrupt_status_out, .system_mode_sleep_out, .power_select_out);

// ### test/testbench.sv
// Self-checking bench for the auto wake/sleep block
`timescale 1ns/1ps
module testbench;
  import aws_pkg::*;
  logic clk_in = '0, rst_n_in = '0, tick_en = '0, flex_mode_in = '0;
  logic wake_sleep_event_enable_in = '0, odr_tick_in, system_mode_read_in;
  logic [3:0] pls = '0;
  wire logic boot_finished_in = pls[0], soft_reset_in = pls[1];
  wire logic hibernate_exit_in = pls[2], any_event_in = pls[3];
  logic [7:0] inactivity_count_low_in = '0, inactivity_count_high_in = '0;
  logic [1:0] wake_power_select_in = '0, sleep_power_select_in = '0;
  logic [3:0] wake_data_rate_in = '0, sleep_data_rate_in = '0;
  logic [3:0] wake_decim_in = '0, sleep_decim_in = '0, wake_idle_in = '0;
  logic [3:0] sleep_idle_in = '0, output_data_rate_out, decim_out, idle_out;
  logic [1:0] power_select_out;
  logic [7:0] interrupt_status_out;
  logic       system_mode_sleep_out;
  int         seed = 68750, errors = 0, n_tests = 0, lim;
  aws_wake_sleep dut_u (.*);
  aws_host_model host_u (.clk_in, .tick_en_in(tick_en),
    .odr_tick_out(odr_tick_in), .mode_read_out(system_mode_read_in));
  always #25 clk_in = ~clk_in;
  task automatic cyc(int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pulse(int b);
    @(posedge clk_in) pls[b] <= 1'h1;
    @(posedge clk_in) pls[b] <= 1'h0;
  endtask
  function automatic logic [15:0] got();
    return {power_select_out, output_data_rate_out, decim_out, idle_out};
  endfunction
  function automatic logic [15:0] exp_set(logic s);
    logic [7:0] fx;
    fx = s ? {sleep_decim_in, sleep_idle_in} : {wake_decim_in, wake_idle_in};
    return {s ? {sleep_power_select_in, sleep_data_rate_in}
              : {wake_power_select_in, wake_data_rate_in},
            flex_mode_in ? fx : 8'h00};
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    #1000000;
    errors++;
    wrap_up();
  end
  initial begin
    cyc(16);
    rst_n_in <= 1'h1;
    cyc(3);
    check("wake set", got(), exp_set(1'h0));
    for (int k = 1; k < 3; k++) begin
      check("boot low", interrupt_status_out[0], 1'h0);
      pulse(0);
      cyc(1);
      check("boot set", interrupt_status_out[0], 1'h1);
      pulse(k);
      cyc(1);
    end
    $display("done boot");
    for (int i = 0; i < 7; i++) begin
      lim = (i == 0) ? 1 : (i == 6) ? 0 : 2 + ($random(seed) & 7);
      @(posedge clk_in);
      {wake_power_select_in, sleep_power_select_in, wake_data_rate_in,
       sleep_data_rate_in, flex_mode_in, wake_decim_in, sleep_decim_in,
       wake_idle_in, sleep_idle_in} <= $random(seed);
      {inactivity_count_high_in, inactivity_count_low_in} <= lim[15:0];
      wake_sleep_event_enable_in <= (i == 6) | i[0];
      tick_en <= 1'h1;
      cyc(lim - 1);
      pulse(3);
      cyc(lim);
      check("quiet restart", system_mode_sleep_out, 1'h0);
      cyc(lim + 20);
      tick_en <= 1'h0;
      check("to sleep", system_mode_sleep_out, lim != 0);
      check("sleep flag", interrupt_status_out[1], lim != 0 && i[0]);
      check("spare bits", interrupt_status_out[7:2], 6'h00);
      if (lim == 0) break;
      check("sleep set", got(), exp_set(1'h1));
      host_u.read_mode();
      cyc(1);
      check("flag read", interrupt_status_out[1], 1'h0);
      pulse(3);
      cyc(2);
      check("to wake", system_mode_sleep_out, 1'h0);
      check("wake flag", interrupt_status_out[1], i[0]);
      check("wake back", got(), exp_set(1'h0));
      host_u.read_mode();
      $display("done cycle %0d", i);
    end
    wrap_up();
  end
endmodule
